// ===== rtl/sclr_pkg.sv
package sclr_pkg;

  // ****************************************************************
  // dataway geometry
  // ****************************************************************
  localparam int unsigned DW_WIDTH     = 24;
  localparam int unsigned ADDR_WIDTH   = 20;
  localparam int unsigned WORD_WIDTH   = 12;
  localparam int unsigned CNT5_WIDTH   = 5;
  localparam int unsigned STEP_WIDTH   = 9;

  // ****************************************************************
  // function and subaddress codes
  // ****************************************************************
  localparam logic [4:0] FN_READ       = 5'h00;
  localparam logic [4:0] FN_IDENT      = 5'h06;
  localparam logic [4:0] FN_SETUP      = 5'h11;
  localparam logic [4:0] FN_STANDBY    = 5'h18;
  localparam logic [4:0] FN_ARM        = 5'h1a;
  localparam logic [3:0] SA_ZERO       = 4'h0;
  localparam logic [3:0] SA_MULT_MAX   = 4'h8;
  localparam logic [3:0] SA_MULT_ONE   = 4'h1;

  // ****************************************************************
  // timing and reset values
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LAMP_TIME_MS  = 100;
  localparam int unsigned LAMP_CYCLES   = LAMP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 20'h00000;
  localparam logic [STEP_WIDTH-1:0] STEP_RESET = 9'h001;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    SCLR_STANDBY,
    SCLR_ARMED,
    SCLR_READBACK
  } sclr_mode_e;

  // one dataway cycle as seen by this station
  typedef struct packed {
    logic       strobe;
    logic       station;
    logic [4:0] func;
    logic [3:0] subaddr;
    logic [DW_WIDTH-1:0] wdata;
  } sclr_cmd_s;

  // answer of this station to a dataway cycle
  typedef struct packed {
    logic                valid;
    logic [DW_WIDTH-1:0] rdata;
    logic                q;
    logic                x;
  } sclr_rsp_s;

  typedef struct packed {
    logic                  addressed;
    logic                  responded;
    logic                  armed;
    logic                  readback;
    logic                  transfer;
    logic [CNT5_WIDTH-1:0] channels;
    logic [CNT5_WIDTH-1:0] memories;
  } sclr_lamp_s;

endpackage : sclr_pkg

// ===== rtl/sclr_stretch.sv
`timescale 1ns/10ps
module sclr_stretch
  import sclr_pkg::*;
#(
  parameter int unsigned CYCLES = LAMP_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_n_i,
  input  wire logic clk_en_i,
  input  wire logic trigger_i,
  output logic      lamp_o
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  // ****************************************************************
  // retriggerable down counter
  // ****************************************************************
  always_comb begin
    next_count = count;
    if (trigger_i) begin
      next_count = CW'(CYCLES); // RULE15
    end else if (count != '0) begin
      next_count = count - CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      count <= '0;
    end else if (clk_en_i) begin
      count <= next_count;
    end
  end

  assign lamp_o = (count != '0);

endmodule : sclr_stretch

// ===== rtl/sclr_ident.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: identification read returns id code, Q=X=1
// RULE2: clear or initialize forces standby mode
// RULE3: station access flashes addressed lamp 100 ms
// RULE4: Q=1 answer flashes response lamp 100 ms
// RULE5: armed lamp lit exactly while armed
// RULE6: readback lamp lit exactly while readback
// RULE7: transfer lamp lit, stretched to 100 ms
// RULE8: five lamps show active channel count
// RULE9: five lamps show attached memory count
// RULE10: subaddress zero gives one-word sequential step
// RULE11: channel step is multiplier times channels
// RULE12: controller loads start address and stride
// RULE13: 0 one, 1-8 multiple, 9-15 as 1
// RULE14: data read returns 12 bits, steps address
// RULE15: stretchers are retriggerable clock counters
// RULE16: counts come from static configuration inputs
module sclr_ident
  import sclr_pkg::*;
#(
  parameter int unsigned         LAMP_CNT = LAMP_CYCLES,
  parameter logic [DW_WIDTH-1:0] ID_CODE  = 24'h000123 // arbitrary value
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   clk_en_i,
  input  wire sclr_cmd_s              cmd_i,
  input  wire logic                   clear_i,
  input  wire logic                   init_i,
  input  wire logic [CNT5_WIDTH-1:0]  channels_i,
  input  wire logic [CNT5_WIDTH-1:0]  memories_i,
  input  wire logic [WORD_WIDTH-1:0]  mem_data_i,
  output sclr_rsp_s                   rsp_o,
  output logic [ADDR_WIDTH-1:0]       mem_addr_o,
  output sclr_lamp_s                  lamp_o
);

  // ****************************************************************
  // step decode
  // ****************************************************************
  function automatic logic [STEP_WIDTH-1:0] step_of(input logic [3:0]            sa,
                                                    input logic [CNT5_WIDTH-1:0] ch);
    logic [3:0] mult;
    mult = sa;
    if (sa > SA_MULT_MAX) begin
      mult = SA_MULT_ONE; // RULE13
    end
    if (sa == SA_ZERO) begin
      step_of = STEP_RESET; // RULE10
    end else begin
      step_of = STEP_WIDTH'(mult * ch); // RULE11
    end
  endfunction : step_of

  function automatic logic is_cmd(input sclr_cmd_s c, input logic [4:0] f,
                                  input logic [3:0] a);
    is_cmd = c.strobe && c.station && (c.func == f) && (c.subaddr == a);
  endfunction : is_cmd

  sclr_mode_e            mode;
  sclr_mode_e            next_mode;
  logic [ADDR_WIDTH-1:0] addr;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [STEP_WIDTH-1:0] step;
  logic [STEP_WIDTH-1:0] next_step;
  logic [3:0]            step_sa;
  logic [3:0]            next_step_sa;
  sclr_rsp_s             rsp;
  sclr_rsp_s             next_rsp;
  logic [CNT5_WIDTH-1:0] channels;
  logic [CNT5_WIDTH-1:0] memories;
  logic                  addr_trig;
  logic                  q_trig;
  logic                  xfer_trig;
  logic                  addr_lamp;
  logic                  q_lamp;
  logic                  xfer_lamp;
  logic                  mem_end;

  assign mem_end = ({1'b0, addr} >> 15) >= (ADDR_WIDTH + 1)'(memories);

  // ****************************************************************
  // command decode
  // ****************************************************************
  always_comb begin
    next_mode    = mode;
    next_addr    = addr;
    next_step_sa = step_sa;
    next_step    = step_of(step_sa, channels); // RULE16
    next_rsp     = '0;
    if (cmd_i.strobe && cmd_i.station) begin
      next_rsp.valid = 1'b1;
      next_rsp.x     = 1'b1;
      if (is_cmd(cmd_i, FN_IDENT, SA_ZERO)) begin
        next_rsp.rdata = ID_CODE; // RULE1
        next_rsp.q     = 1'b1;
      end else if (is_cmd(cmd_i, FN_STANDBY, SA_ZERO)) begin
        next_mode  = SCLR_STANDBY;
        next_rsp.q = 1'b1;
      end else if (is_cmd(cmd_i, FN_ARM, SA_ZERO)) begin
        next_mode  = SCLR_ARMED;
        next_rsp.q = 1'b1;
      end else if (cmd_i.func == FN_SETUP) begin
        next_mode    = SCLR_READBACK;
        next_addr    = cmd_i.wdata[ADDR_WIDTH-1:0];
        next_step_sa = cmd_i.subaddr;
        next_rsp.q   = 1'b1;
      end else if (is_cmd(cmd_i, FN_READ, SA_ZERO)) begin
        if (mode == SCLR_READBACK && !mem_end) begin
          next_rsp.rdata = {{(DW_WIDTH - WORD_WIDTH){1'b0}}, mem_data_i}; // RULE14
          next_rsp.q     = 1'b1;
          next_addr      = addr + ADDR_WIDTH'(step); // RULE14
        end
      end else begin
        next_rsp.x = 1'b0;
      end
    end
    if (clear_i || init_i) begin
      next_mode = SCLR_STANDBY; // RULE2
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      mode     <= SCLR_STANDBY;
      addr     <= ADDR_RESET;
      step     <= STEP_RESET;
      step_sa  <= SA_ZERO;
      rsp      <= '0;
      channels <= '0;
      memories <= '0;
    end else if (clk_en_i) begin
      mode     <= next_mode;
      addr     <= next_addr;
      step     <= next_step;
      step_sa  <= next_step_sa;
      rsp      <= next_rsp;
      channels <= channels_i; // RULE16
      memories <= memories_i; // RULE16
    end
  end

  // ****************************************************************
  // lamps
  // ****************************************************************
  assign addr_trig = cmd_i.strobe && cmd_i.station; // RULE3
  assign q_trig    = rsp.valid && rsp.q; // RULE4
  assign xfer_trig = next_rsp.q && is_cmd(cmd_i, FN_READ, SA_ZERO); // RULE7

  sclr_stretch #(.CYCLES(LAMP_CNT)) u_addr_lamp (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .trigger_i (addr_trig),
    .lamp_o    (addr_lamp)
  );

  sclr_stretch #(.CYCLES(LAMP_CNT)) u_q_lamp (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .trigger_i (q_trig),
    .lamp_o    (q_lamp)
  );

  sclr_stretch #(.CYCLES(LAMP_CNT)) u_xfer_lamp (
    .ref_clk_i (ref_clk_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .trigger_i (xfer_trig),
    .lamp_o    (xfer_lamp)
  );

  sclr_lamp_s lamp;
  sclr_lamp_s next_lamp;
  logic [ADDR_WIDTH-1:0] mem_addr;

  always_comb begin
    next_lamp.addressed = addr_lamp; // RULE3
    next_lamp.responded = q_lamp; // RULE4
    next_lamp.armed     = (next_mode == SCLR_ARMED); // RULE5
    next_lamp.readback  = (next_mode == SCLR_READBACK); // RULE6
    next_lamp.transfer  = xfer_lamp || xfer_trig; // RULE7
    next_lamp.channels  = channels; // RULE8
    next_lamp.memories  = memories; // RULE9
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      lamp     <= '0;
      mem_addr <= ADDR_RESET;
    end else if (clk_en_i) begin
      lamp     <= next_lamp;
      mem_addr <= next_addr;
    end
  end

  assign lamp_o     = lamp;
  assign mem_addr_o = mem_addr;
  assign rsp_o      = rsp;

endmodule : sclr_ident

// ===== verif/sclr_ident_props.sv
`timescale 1ns/10ps
module sclr_ident_props
  import sclr_pkg::*;
#(
  parameter logic [DW_WIDTH-1:0] ID_CODE = 24'h000000
) (
  input wire logic                  ref_clk_i,
  input wire logic                  reset_n_i,
  input wire logic                  clk_en_i,
  input wire sclr_cmd_s             cmd_i,
  input wire logic                  clear_i,
  input wire logic                  init_i,
  input wire logic [CNT5_WIDTH-1:0] channels_i,
  input wire logic [CNT5_WIDTH-1:0] memories_i,
  input wire logic [WORD_WIDTH-1:0] mem_data_i,
  input wire sclr_rsp_s             rsp_o,
  input wire logic [ADDR_WIDTH-1:0] mem_addr_o,
  input wire sclr_lamp_s            lamp_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic take = cmd_i.strobe && cmd_i.station && clk_en_i;
  wire logic cz   = clear_i || init_i;
  wire logic rd   = take && cmd_i.func == FN_READ && cmd_i.subaddr == SA_ZERO;
  a_ident_answer: assert property (take && cmd_i.func == FN_IDENT && cmd_i.subaddr == SA_ZERO
    |=> rsp_o.valid && rsp_o.q && rsp_o.x && rsp_o.rdata == ID_CODE) else $error("ident answer");
  a_clear_standby: assert property (cz && clk_en_i
    |=> !lamp_o.armed && !lamp_o.readback) else $error("clear not standby");
  a_addr_lamp: assert property (take |-> ##2 lamp_o.addressed) else $error("addr lamp");
  a_resp_lamp: assert property (rsp_o.valid && rsp_o.q
    |-> ##2 lamp_o.responded) else $error("resp lamp");
  a_arm_lamp: assert property (take && cmd_i.func == FN_ARM && cmd_i.subaddr == SA_ZERO && !cz
    |=> lamp_o.armed && !lamp_o.readback) else $error("armed lamp");
  a_rdbk_lamp: assert property (take && cmd_i.func == FN_SETUP && !cz
    |=> lamp_o.readback && !lamp_o.armed) else $error("readback lamp");
  a_count_lamps: assert property ($past(reset_n_i) && $past(clk_en_i) && clk_en_i
    && $stable(channels_i) && $stable(memories_i)
    |=> lamp_o.channels == $past(channels_i) && lamp_o.memories == $past(memories_i))
    else $error("count lamps");
  a_read_word: assert property (rd |=> rsp_o.rdata[23:12] == 12'h000
    && (rsp_o.q ? rsp_o.rdata[11:0] == $past(mem_data_i) : rsp_o.rdata == 24'h000000))
    else $error("read word");
  a_refuse_hold: assert property (rd |=> rsp_o.q || $stable(mem_addr_o))
    else $error("refused read moved address");
  a_xfer_lamp: assert property (rd ##1 rsp_o.q |-> ##[0:2] lamp_o.transfer)
    else $error("transfer lamp");
  a_lamp_stretch: assert property ($rose(lamp_o.addressed) |-> lamp_o.addressed [*8])
    else $error("lamp too short");
endmodule : sclr_ident_props
bind sclr_ident sclr_ident_props #(.ID_CODE(ID_CODE)) u_props (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i), .cmd_i(cmd_i),
  .clear_i(clear_i), .init_i(init_i), .channels_i(channels_i), .memories_i(memories_i),
  .mem_data_i(mem_data_i), .rsp_o(rsp_o), .mem_addr_o(mem_addr_o), .lamp_o(lamp_o));

// ===== verif/sclr_ctrl_model.sv
`timescale 1ns/10ps
module sclr_ctrl_model
  import sclr_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire sclr_rsp_s rsp_i,
  output sclr_cmd_s      cmd_o,
  output logic           clear_o,
  output logic           init_o
);
  sclr_rsp_s last;
  initial begin
    cmd_o   = '0;
    clear_o = 1'b0;
    init_o  = 1'b0;
  end
  // one dataway cycle; start address and stride come in w and a
  task automatic cycle(input logic [4:0] f, input logic [3:0] a, input logic [23:0] w);
    @(negedge ref_clk_i);
    cmd_o = '{1'b1, 1'b1, f, a, w};
    @(negedge ref_clk_i);
    // the answer stands for one cycle only, so take it before releasing
    last  = rsp_i;
    // released lines show the inverse, not the last value
    cmd_o = '{1'b0, 1'b0, ~f, ~a, ~w};
    @(negedge ref_clk_i);
  endtask : cycle
  task automatic crate_cz(input logic c, input logic z);
    @(negedge ref_clk_i);
    clear_o = c;
    init_o  = z;
    @(negedge ref_clk_i);
    clear_o = 1'b0;
    init_o  = 1'b0;
    @(negedge ref_clk_i);
  endtask : crate_cz
endmodule : sclr_ctrl_model

// ===== verif/scaler_ident_lamps_readback_step_tb.sv
`timescale 1ns/10ps
module scaler_ident_lamps_readback_step_tb
  import sclr_pkg::*;
;
  localparam logic [23:0] ID = 24'h00a5c3; // arbitrary value
  logic ref_clk = 1'b0, reset_n = 1'b0;
  logic [4:0] ch = 5'h18, mem = 5'h01;
  logic clk_en = 1'b1;
  sclr_cmd_s cmd;
  sclr_rsp_s rsp;
  sclr_lamp_s lamp;
  logic clear, init;
  logic [19:0] maddr;
  int fails = 0, comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  sclr_ctrl_model ctl (.ref_clk_i(ref_clk), .rsp_i(rsp), .cmd_o(cmd), .clear_o(clear), .init_o(init));
  sclr_ident #(.LAMP_CNT(20), .ID_CODE(ID)) uut (.ref_clk_i(ref_clk), .reset_n_i(reset_n),
    .clk_en_i(clk_en), .cmd_i(cmd), .clear_i(clear), .init_i(init), .channels_i(ch),
    .memories_i(mem), .mem_data_i(maddr[11:0] ^ 12'h5a5), .rsp_o(rsp), .mem_addr_o(maddr),
    .lamp_o(lamp));
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic finish_test();
    if (fails == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task automatic t_modes();
    ctl.cycle(FN_IDENT, SA_ZERO, 24'h0);
    chk("ident", ID, ctl.last.rdata);
    chk("ident vqx", 24'h7, 24'({ctl.last.valid, ctl.last.q, ctl.last.x}));
    ctl.cycle(FN_ARM, SA_ZERO, 24'h0);
    chk("armed", 24'h2, 24'({lamp.armed, lamp.readback}));
    ctl.cycle(FN_IDENT, SA_ZERO, 24'h0);
    chk("ident armed", ID, ctl.last.rdata);
    ctl.cycle(FN_READ, SA_ZERO, 24'h0);
    chk("armed read", 24'h1, {ctl.last.rdata[21:0], ctl.last.q, ctl.last.x});
    ctl.crate_cz(1'b1, 1'b0);
    chk("clear", 24'h0, 24'({lamp.armed, lamp.readback}));
    ctl.cycle(FN_SETUP, SA_ZERO, 24'h0);
    chk("rdbk", 24'h1, 24'({lamp.armed, lamp.readback}));
    ctl.crate_cz(1'b0, 1'b1);
    chk("init", 24'h0, 24'({lamp.armed, lamp.readback}));
    ctl.cycle(5'h09, SA_ZERO, 24'h0);
    chk("unknown", 24'h4, 24'({ctl.last.valid, ctl.last.q, ctl.last.x}));
  endtask : t_modes
  task automatic t_steps(input logic [4:0] c);
    int step;
    ch = c;
    for (int n = 0; n < 16; n++) begin
      step = (n == 0) ? 1 : (n <= 8) ? n * c : c;
      ctl.cycle(FN_SETUP, 4'(n), 24'h3);
      ctl.cycle(FN_READ, SA_ZERO, 24'h0);
      chk("word", {12'h0, 12'h003 ^ 12'h5a5}, ctl.last.rdata);
      chk("step", 24'(3 + step), 24'(maddr));
      chk("xfer", 24'h1, 24'(lamp.transfer));
    end
    chk("ch lamps", 24'(c), 24'(lamp.channels));
  endtask : t_steps
  task automatic t_end();
    mem = 5'h02;
    ctl.cycle(FN_SETUP, SA_ZERO, 24'h00ffff);
    ctl.cycle(FN_READ, SA_ZERO, 24'h0);
    chk("last q", 24'h3, 24'({ctl.last.q, ctl.last.x}));
    ctl.cycle(FN_READ, SA_ZERO, 24'h0);
    chk("end", 24'h1, {ctl.last.rdata[21:0], ctl.last.q, ctl.last.x});
    chk("end addr", 24'h010000, 24'(maddr));
    chk("mem lamps", 24'h2, 24'(lamp.memories));
    // with the clock enable low an arm command must leave readback mode alone
    clk_en = 1'b0;
    ctl.cycle(FN_ARM, SA_ZERO, 24'h0);
    chk("frozen", 24'h1, 24'({lamp.armed, lamp.readback}));
    clk_en = 1'b1;
  endtask : t_end
  task automatic t_stretch();
    ctl.cycle(FN_IDENT, SA_ZERO, 24'h0);
    repeat (2) @(negedge ref_clk);
    chk("n q lamps", 24'h3, 24'({lamp.addressed, lamp.responded}));
    repeat (12) @(negedge ref_clk);
    ctl.cycle(FN_IDENT, SA_ZERO, 24'h0);
    repeat (14) @(negedge ref_clk);
    chk("retrigger", 24'h3, 24'({lamp.addressed, lamp.responded}));
    repeat (25) @(negedge ref_clk);
    chk("lamps off", 24'h0, 24'({lamp.addressed, lamp.responded, lamp.transfer}));
  endtask : t_stretch
  initial begin
    repeat (2) @(negedge ref_clk);
    reset_n = 1'b1;
    t_modes();
    t_steps(5'h18);
    t_steps(5'h07);
    t_end();
    t_stretch();
    finish_test();
  end
  initial begin
    #100000;
    fails++;
    finish_test();
  end
endmodule : scaler_ident_lamps_readback_step_tb
